// [core/i2c_link_consts.svh]
`ifndef I2C_LINK_CONSTS_SVH
`define I2C_LINK_CONSTS_SVH
// Target address, low bit from the strap
`define DEV_ADDR_BASE   7'h18
`define RD_START_RESET  8'h00
// Clock periods
`define CLK_PERIOD_NS   50
`define LINK_PERIOD_NS  6
// Bus bit time, quarter of it in host clocks (rounded up)
`define SCL_PERIOD_NS   2500
`define QTR_CYC ((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Post-write idle times
`define IDLE_NORM_NS    2000
`define IDLE_SUSP_NS    450000
`define IDLE_NORM_CYC ((`IDLE_NORM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_SUSP_CYC ((`IDLE_SUSP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Lockup watchdog periods
`define WDT_SHORT_NS    1000000
`define WDT_LONG_NS     50000000
`define WDT_SHORT_CYC ((`WDT_SHORT_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)
`define WDT_LONG_CYC  ((`WDT_LONG_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)
// Byte bit count and last data bit index
`define BYTE_BITS       4'h8
`define LAST_DATA_BIT   4'h7
// Host sequence stages
`define STG_ADDR_W      3'h0
`define STG_REG         3'h1
`define STG_DATA        3'h2
`define STG_ADDR_R      3'h3
`define STG_READ        3'h4
`endif

// [core/i2c_link_pkg.sv]
`include "i2c_link_consts.svh"
package i2c_link_pkg;
   // Target port states
   typedef enum logic [5:0] {
      T_IDLE   = 6'h01,
      T_RX     = 6'h02,
      T_ACK    = 6'h04,
      T_TX     = 6'h08,
      T_RACK   = 6'h10,
      T_IGNORE = 6'h20
   } tgt_state_e;
   // Meaning of the byte being received
   typedef enum logic [3:0] {
      K_ADDR = 4'h1,
      K_REG  = 4'h2,
      K_DATA = 4'h4,
      K_DONE = 4'h8
   } rx_kind_e;
   // Controller states
   typedef enum logic [4:0] {
      H_IDLE  = 5'h01,
      H_START = 5'h02,
      H_BYTE  = 5'h04,
      H_STOP  = 5'h08,
      H_GAP   = 5'h10
   } ctl_state_e;
   // Own address from the strap level
   function automatic logic [6:0] dev_addr(input logic sel);
      dev_addr = `DEV_ADDR_BASE | {6'h00, sel};
   endfunction
endpackage

// [core/i2c_link_if.sv]
`timescale 1ns/10ps
interface i2c_link_if;
   logic      scl_o;        // Controller clock drive value
   logic      scl_oe;       // Controller pulls clock line
   logic      host_sda_o;   // Controller data drive value
   logic      host_sda_oe;  // Controller pulls data line
   logic      dev_sda_o;    // Target data drive value
   logic      dev_sda_oe;   // Target pulls data line
   wire logic scl;          // Resolved clock line
   wire logic sda;          // Resolved data line
   // Open drain with pull-ups
   assign scl = ~scl_oe | scl_o;
   assign sda = (~host_sda_oe | host_sda_o) & (~dev_sda_oe | dev_sda_o);
   modport host (output scl_o, scl_oe, host_sda_o, host_sda_oe, input scl, sda);
   modport device (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// [core/sync2.sv]
`timescale 1ns/10ps
module sync2 #(
   parameter int unsigned       WIDTH = 1,
   parameter logic [WIDTH-1:0]  INIT  = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;  // First stage, read only by q
   // Two-flop synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // sync2

// [core/i2c_ctl_end.sv]
`timescale 1ns/10ps
`include "i2c_link_consts.svh"
module i2c_ctl_end import i2c_link_pkg::*; #(
   parameter int unsigned GAP_SUSP_CYC = `IDLE_SUSP_CYC
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   i2c_link_if.host        bus,
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic [7:0] cmd_reg,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic [7:0] cmd_len,
   input  wire logic       addr_sel,
   input  wire logic       suspend_mode,
   output logic            cmd_ready,
   output logic            rd_valid,
   output logic      [7:0] rd_data,
   output logic            done,
   output logic            nack_err
);
   ctl_state_e  st_reg;     // Sequencer state
   logic [1:0]  q_reg;      // Quarter of bit time
   logic [7:0]  div_reg;    // Quarter divider
   logic [3:0]  bit_reg;    // Bit within byte, 8 is ack
   logic [7:0]  sh_reg;     // Shift register
   logic [2:0]  stage_reg;  // Which byte of the transfer
   logic [7:0]  left_reg;   // Read bytes still wanted
   logic        rd_reg;     // Transfer is a read
   logic [7:0]  reg_reg;    // Register address
   logic [7:0]  wd_reg;     // Write data
   logic [6:0]  ta_reg;     // Target address
   logic        wrote_reg;  // A data byte was written
   logic [13:0] gap_reg;    // Post-write idle counter
   logic        scl_oe_reg;
   logic        sda_oe_reg;
   logic        sda_s;      // Synchronised data line
   // Data line sampled through two flops
   sync2 #(.WIDTH(1), .INIT(1'b1)) u_sync (
      .clk(clock), .rst_n(rst_n), .d(bus.sda), .q(sda_s));
   // Named decodes
   wire        tick     = div_reg == 8'(`QTR_CYC - 1);
   wire        rx_stage = stage_reg == `STG_READ;
   wire        ack_seen = ~sda_s;
   wire [13:0] gap_lim  = suspend_mode ? 14'(GAP_SUSP_CYC) : 14'(`IDLE_NORM_CYC);
   wire        gap_end  = gap_reg >= gap_lim - 14'h0001;
   assign bus.scl_o       = 1'b0;
   assign bus.host_sda_o  = 1'b0;
   assign bus.scl_oe      = scl_oe_reg;
   assign bus.host_sda_oe = sda_oe_reg;
   // Quarter divider runs while a frame is on the bus
   always_ff @(posedge clock) begin
      if (!rst_n || st_reg == H_IDLE || st_reg == H_GAP || tick) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   // Frame sequencer
   always_ff @(posedge clock) begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      nack_err <= 1'b0;
      if (!rst_n) begin
         st_reg <= H_IDLE;  q_reg <= 2'h0;  bit_reg <= 4'h0;
         sh_reg <= 8'h00;   stage_reg <= `STG_ADDR_W;  left_reg <= 8'h00;
         rd_reg <= 1'b0;    reg_reg <= 8'h00;  wd_reg <= 8'h00;
         ta_reg <= 7'h00;   wrote_reg <= 1'b0;  gap_reg <= 14'h0000;
         scl_oe_reg <= 1'b0;  sda_oe_reg <= 1'b0;
         cmd_ready <= 1'b0;  rd_data <= 8'h00;
      end else begin
         unique case (st_reg)
            // Take a command, address first with write bit
            H_IDLE: begin
               cmd_ready <= ~cmd_valid;
               if (cmd_valid) begin
                  st_reg <= H_START;  q_reg <= 2'h0;
                  ta_reg <= dev_addr(addr_sel);
                  sh_reg <= {dev_addr(addr_sel), 1'b0};
                  stage_reg <= `STG_ADDR_W;  rd_reg <= cmd_read;
                  reg_reg <= cmd_reg;  wd_reg <= cmd_wdata;
                  left_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                  wrote_reg <= 1'b0;
               end
            end
            H_START: if (tick) begin
               q_reg <= q_reg + 2'h1;
               unique case (q_reg)
                  2'h0: scl_oe_reg <= 1'b0;
                  2'h1: sda_oe_reg <= 1'b1;
                  2'h2: scl_oe_reg <= 1'b1;
                  2'h3: begin
                     st_reg <= H_BYTE;  bit_reg <= 4'h0;
                     sda_oe_reg <= ~sh_reg[7];
                  end
               endcase
            end
            H_BYTE: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (q_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  bit_reg    <= bit_reg + 4'h1;
                  if (bit_reg < `LAST_DATA_BIT) begin
                     sh_reg     <= {sh_reg[6:0], sda_s};
                     sda_oe_reg <= rx_stage ? 1'b0 : ~sh_reg[6];
                  end else if (bit_reg == `LAST_DATA_BIT) begin
                     sh_reg <= {sh_reg[6:0], sda_s};
                     sda_oe_reg <= rx_stage && left_reg != 8'h01;
                  end else begin
                     bit_reg <= 4'h0;
                     sda_oe_reg <= 1'b0;
                     if (rx_stage) begin
                        rd_valid <= 1'b1;  rd_data <= sh_reg;
                        left_reg <= left_reg - 8'h01;
                        if (left_reg == 8'h01) begin
                           st_reg <= H_STOP;  sda_oe_reg <= 1'b1;
                        end
                     end else if (!ack_seen) begin
                        nack_err <= 1'b1;  st_reg <= H_STOP;  sda_oe_reg <= 1'b1;
                     end else begin
                        unique case (stage_reg)
                           `STG_ADDR_W: begin
                              stage_reg <= `STG_REG;  sh_reg <= reg_reg;
                              sda_oe_reg <= ~reg_reg[7];
                           end
                           `STG_REG: if (rd_reg) begin
                              stage_reg <= `STG_ADDR_R;  st_reg <= H_START;
                              sh_reg <= {ta_reg, 1'b1};
                           end else begin
                              stage_reg <= `STG_DATA;  sh_reg <= wd_reg;
                              sda_oe_reg <= ~wd_reg[7];
                           end
                           `STG_DATA: begin
                              wrote_reg <= 1'b1;  st_reg <= H_STOP;  sda_oe_reg <= 1'b1;
                           end
                           `STG_ADDR_R: stage_reg <= `STG_READ;
                           default: begin
                              st_reg <= H_STOP;  sda_oe_reg <= 1'b1;
                           end
                        endcase
                     end
                  end
               end
            end
            H_STOP: if (tick) begin
               q_reg <= q_reg + 2'h1;
               unique case (q_reg)
                  2'h0: scl_oe_reg <= 1'b0;
                  2'h1: sda_oe_reg <= 1'b0;
                  2'h2: ;
                  2'h3: begin
                     st_reg  <= wrote_reg ? H_GAP : H_IDLE;
                     gap_reg <= 14'h0000;
                     done    <= 1'b1;
                  end
               endcase
            end
            H_GAP: begin
               gap_reg <= gap_reg + 14'h0001;
               if (gap_end) begin
                  st_reg <= H_IDLE;
               end
            end
         endcase
      end
   end
endmodule // i2c_ctl_end

// [core/accel_i2c_target_port.sv]
`timescale 1ns/10ps
`include "i2c_link_consts.svh"
// Functional notes
// - Seven-bit addressing only, both speeds
// - Address 0x18 or 0x19 by strap
// - Start: data falls while clock high
// - Stop: data rises, clock high; idle
// - Receiver target_acknowledge each byte, ninth clock; target leaves bytes after the first data byte unacked
// - Stop right after start is ignored
// - Write: address, register, data, stop
// - One data byte stored per write
// - Read: write phase, repeated start, read
// - Controller ack continues, nack ends sending
// - Read pointer increments per byte the controller acks
// - Reads start at last written address
// - Watchdog resets interface on lockup
// - Enable bit switches watchdog
// - Select bit picks 1 or 50 ms
// - Controller idles 2 us after write
// - Controller idles 450 us in suspend
module accel_i2c_target_port import i2c_link_pkg::*; #(
   parameter int unsigned WDT_SHORT_CYC = `WDT_SHORT_CYC,
   parameter int unsigned WDT_LONG_CYC  = `WDT_LONG_CYC
) (
   input  wire logic       link_clk,
   input  wire logic       rst_n,
   i2c_link_if.device      bus,
   input  wire logic       addr_sel_pin,
   input  wire logic       wdt_en,
   input  wire logic       wdt_sel,
   input  wire logic [7:0] rd_data,
   output logic            wr_en,
   output logic      [7:0] wr_addr,
   output logic      [7:0] wr_data,
   output logic      [7:0] rd_addr,
   output logic            wdt_trip,
   output logic            busy
);
   tgt_state_e  state_reg;     // Target state
   rx_kind_e    kind_reg;      // Meaning of byte in flight
   logic [3:0]  bit_reg;       // Bits moved in this byte
   logic [7:0]  sh_reg;        // Receive shift register
   logic [7:0]  tx_reg;        // Transmit shift register
   logic        rw_reg;        // Direction bit of address
   logic [7:0]  base_reg;      // Last written register address
   logic        mack_reg;      // Controller ack seen
   logic        fall_seen_reg; // Clock fell since start
   logic        sda_oe_reg;    // Pulling data line low
   logic        scl_d_reg;     // Clock, one cycle old
   logic        sda_d_reg;     // Data, one cycle old
   logic [23:0] wdt_reg;       // Lockup counter
   logic        scl_s;         // Synchronised clock line
   logic        sda_s;         // Synchronised data line
   logic        sel_s;         // Synchronised strap

   // Pins pass two flops before use
   sync2 #(.WIDTH(3), .INIT(3'b110)) u_sync (
      .clk   (link_clk),
      .rst_n (rst_n),
      .d     ({bus.scl, bus.sda, addr_sel_pin}),
      .q     ({scl_s, sda_s, sel_s})
   );

   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = sda_oe_reg;

   // Edge and condition decode
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   // stop counts only after a clock fall
   wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s & fall_seen_reg;
   wire byte_full = bit_reg == `BYTE_BITS;
   wire addr_hit = sh_reg[7:1] == dev_addr(sel_s);

   wire [23:0] wdt_lim = wdt_sel ? 24'(WDT_LONG_CYC) : 24'(WDT_SHORT_CYC);
   // restart on release or clock activity
   wire wdt_clr = ~wdt_en | ~sda_oe_reg | scl_rise | scl_fall;
   wire wdt_fire = ~wdt_clr & (wdt_reg >= wdt_lim - 24'h000001);

   // Line history for edge detection
   always_ff @(posedge link_clk) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // Lockup watchdog counter
   always_ff @(posedge link_clk) begin
      if (!rst_n || wdt_clr || wdt_fire) begin
         wdt_reg <= 24'h000000;
      end else begin
         wdt_reg <= wdt_reg + 24'h000001;
      end
   end

   // Status flops
   always_ff @(posedge link_clk) begin
      if (!rst_n) begin
         wdt_trip <= 1'b0;
         busy     <= 1'b0;
      end else begin
         wdt_trip <= wdt_fire;
         busy     <= state_reg != T_IDLE;
      end
   end

   // Frame engine
   always_ff @(posedge link_clk) begin
      wr_en <= 1'b0;
      if (!rst_n || wdt_fire) begin
         state_reg     <= T_IDLE;
         kind_reg      <= K_ADDR;
         bit_reg       <= 4'h0;
         sh_reg        <= 8'h00;
         tx_reg        <= 8'h00;
         rw_reg        <= 1'b0;
         mack_reg      <= 1'b0;
         fall_seen_reg <= 1'b0;
         sda_oe_reg    <= 1'b0;
         if (!rst_n) begin
            base_reg <= `RD_START_RESET;
            rd_addr  <= `RD_START_RESET;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
         end
      end else if (start_det) begin
         // start or repeated start opens address byte
         state_reg     <= T_RX;
         kind_reg      <= K_ADDR;
         bit_reg       <= 4'h0;
         fall_seen_reg <= 1'b0;
         sda_oe_reg    <= 1'b0;
      end else if (stop_det) begin
         state_reg  <= T_IDLE;
         sda_oe_reg <= 1'b0;
      end else begin
         if (scl_fall) begin
            fall_seen_reg <= 1'b1;
         end
         unique case (state_reg)
            T_IDLE, T_IGNORE: ;
            // Receive a byte
            T_RX: if (scl_rise && !byte_full) begin
               sh_reg  <= {sh_reg[6:0], sda_s};
               bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
               unique case (kind_reg)
                  K_ADDR: if (addr_hit) begin
                     state_reg  <= T_ACK;
                     sda_oe_reg <= 1'b1;
                     rw_reg     <= sh_reg[0];
                     kind_reg   <= K_REG;
                     rd_addr    <= base_reg;
                  end else begin
                     state_reg <= T_IGNORE;
                  end
                  K_REG: begin
                     state_reg  <= T_ACK;
                     sda_oe_reg <= 1'b1;
                     base_reg   <= sh_reg;
                     kind_reg   <= K_DATA;
                  end
                  K_DATA: begin
                     state_reg  <= T_ACK;
                     sda_oe_reg <= 1'b1;
                     wr_en      <= 1'b1;
                     wr_addr    <= base_reg;
                     wr_data    <= sh_reg;
                     kind_reg   <= K_DONE;
                  end
                  K_DONE: state_reg <= T_IGNORE;
               endcase
            end
            T_ACK: if (scl_fall) begin
               bit_reg <= 4'h0;
               if (rw_reg) begin
                  state_reg  <= T_TX;
                  tx_reg     <= rd_data;
                  sda_oe_reg <= ~rd_data[7];
                  bit_reg    <= 4'h1;
               end else begin
                  state_reg  <= T_RX;
                  sda_oe_reg <= 1'b0;
               end
            end
            // Shift data out on clock falls
            T_TX: if (scl_fall) begin
               if (byte_full) begin
                  // Release for controller ack slot
                  state_reg  <= T_RACK;
                  sda_oe_reg <= 1'b0;
               end else begin
                  tx_reg     <= {tx_reg[6:0], 1'b0};
                  sda_oe_reg <= ~tx_reg[6];
                  bit_reg    <= bit_reg + 4'h1;
               end
            end
            T_RACK: if (scl_rise) begin
               mack_reg <= ~sda_s;
               if (!sda_s) begin
                  rd_addr <= rd_addr + 8'h01;
               end
            end else if (scl_fall) begin
               if (mack_reg) begin
                  state_reg  <= T_TX;
                  tx_reg     <= rd_data;
                  sda_oe_reg <= ~rd_data[7];
                  bit_reg    <= 4'h1;
               end else begin
                  state_reg <= T_IGNORE;
               end
            end
         endcase
      end
   end
endmodule // accel_i2c_target_port

// [test/i2c_link_assertions.sv]
`timescale 1ns/10ps
// Wire-level checks, sampled on the target clock
module i2c_link_assertions (
   input wire logic link_clk,     // Target clock
   input wire logic rst_n,        // Shared reset
   input wire logic scl_o,        // Controller clock value
   input wire logic scl_oe,       // Controller clock pull
   input wire logic host_sda_o,   // Controller data value
   input wire logic host_sda_oe,  // Controller data pull
   input wire logic dev_sda_o,    // Target data value
   input wire logic dev_sda_oe,   // Target data pull
   input wire logic scl,          // Resolved clock line
   input wire logic sda           // Resolved data line
);
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_n);
   // target lets go only in clock low
   AST_DEV_DROP_LOW: assert property ($fell(dev_sda_oe) |-> !scl)
      else $error("target releases data while clock high");
   // data holds low for eight target clocks after start
   AST_START_HOLD: assert property (scl && $fell(sda) |=> !$rose(sda) [*8])
      else $error("data rose right after start");
   // target grabs data in clock low
   AST_DEV_TAKE_LOW: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("target takes data line while clock high");
   AST_DEV_HOLD_HIGH: assert property (scl && dev_sda_oe |=> dev_sda_oe || !scl)
      else $error("target lets go while clock high");
   AST_NO_FIGHT: assert property (scl && dev_sda_oe |-> !host_sda_oe)
      else $error("both ends pull data in clock high");
   AST_START_BY_HOST: assert property (scl && $fell(sda) |-> host_sda_oe)
      else $error("data fell in clock high without controller");
   AST_QUIET_START: assert property (scl && $fell(sda) |=> !dev_sda_oe [*8])
      else $error("target pulls data right after start");
   AST_STOP_IDLE: assert property (scl && $rose(sda) |-> !dev_sda_oe [*8])
      else $error("target pulls data after stop");
endmodule // i2c_link_assertions

// [test/testbench.sv]
`timescale 1ns/10ps
// Both link ends joined, user sides driven and watched
module testbench import i2c_link_pkg::*;;
   logic        clock = 0, link_clk = 0, rst_n = 0;  // Clocks, reset
   logic        cmd_valid = 0, cmd_read = 0;         // Command strobe, kind
   logic [7:0]  cmd_reg = 0, cmd_wdata = 0, cmd_len = 0;
   logic        addr_sel = 0, suspend_mode = 0;      // Command options
   logic        strap = 0, wdt_sel = 0, wdt_en = 1;  // Target straps, watchdog on
   logic        hold = 0;                            // Freezes the controller
   logic        cmd_ready, rd_valid, done, nack_err; // Controller outputs
   logic [7:0]  rd_byte, reg_out, wr_addr, wr_data, rd_addr;
   logic        wr_en, wdt_trip, busy;               // Target store, status
   logic [7:0]  regs [256];                          // Register file
   logic [7:0]  shadow [256];                        // Expected contents
   logic [7:0]  exp_rd [$];                          // Expected read bytes
   logic [15:0] exp_wr [$];                          // Expected stores
   logic        nack_seen = 0;                       // Nack pulse noted
   int          failures = 0, total_checks = 0, seed = 32'hc043;

   always #25 clock = ~clock;
   // Link clock, off phase from host clock
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   i2c_link_if i2c_link_if_i ();
   i2c_ctl_end #(.GAP_SUSP_CYC(100)) i2c_ctl_end_i (.clock(clock & ~hold), .rst_n(rst_n),
      .bus(i2c_link_if_i), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_reg(cmd_reg),
      .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .addr_sel(addr_sel),
      .suspend_mode(suspend_mode), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
      .rd_data(rd_byte), .done(done), .nack_err(nack_err));
   accel_i2c_target_port #(.WDT_SHORT_CYC(2000), .WDT_LONG_CYC(4000))
      accel_i2c_target_port_i (.link_clk(link_clk), .rst_n(rst_n), .bus(i2c_link_if_i),
      .addr_sel_pin(strap), .wdt_en(wdt_en), .wdt_sel(wdt_sel), .rd_data(reg_out),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .wdt_trip(wdt_trip), .busy(busy));
   i2c_link_assertions i2c_link_assertions_i (.link_clk(link_clk), .rst_n(rst_n),
      .scl_o(i2c_link_if_i.scl_o), .scl_oe(i2c_link_if_i.scl_oe),
      .host_sda_o(i2c_link_if_i.host_sda_o), .host_sda_oe(i2c_link_if_i.host_sda_oe),
      .dev_sda_o(i2c_link_if_i.dev_sda_o), .dev_sda_oe(i2c_link_if_i.dev_sda_oe),
      .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda));

   // Register file behind the target
   assign reg_out = regs[rd_addr];
   always @(posedge link_clk) if (wr_en) regs[wr_addr] <= wr_data;

   task automatic tally(input string what, input logic ok, input logic [15:0] e, s);
      total_checks++;
      if (!ok) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic check_byte(input string w, input logic [7:0] e, s);
      tally(w, s === e, e, s);
   endtask
   task automatic check_word(input string w, input logic [15:0] e, s);
      tally(w, s === e, e, s);
   endtask
   task automatic check_flag(input string w, input logic e, s);
      tally(w, s === e, e, s);
   endtask
   task automatic summarize();
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Read bytes against oldest note, nacks noted
   always @(negedge clock) begin
      if (nack_err === 1'b1) nack_seen = 1;
      if (rd_valid === 1'b1)
         check_byte("read byte", exp_rd.size() ? exp_rd.pop_front() : 8'hxx, rd_byte);
   end
   // Stores against oldest note
   always @(negedge link_clk) begin
      if (wr_en === 1'b1)
         check_word("store", exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx,
                    {wr_addr, wr_data});
   end

   // One command, with its notes and after-checks
   task automatic run(input logic rd, input logic [7:0] rg, wd, ln,
                      input logic sel, strp, susp);
      int   n;
      logic nk;
      nk = (sel != strp);
      for (n = 0; n < ln && !nk && rd; n++) exp_rd.push_back(shadow[8'(rg + n)]);
      if (!nk && !rd) begin
         exp_wr.push_back({rg, wd});
         shadow[rg] = wd;
      end
      nack_seen = 0;
      strap = strp;
      @(negedge clock);
      {cmd_read, cmd_reg, cmd_wdata, cmd_len} = {rd, rg, wd, ln};
      {addr_sel, suspend_mode, wdt_sel} = {sel, susp, 1'($random(seed))};
      cmd_valid = 1;
      @(negedge clock);
      cmd_valid = 0;
      for (n = 0; done !== 1'b1 && n < 9000; n++) @(negedge clock);
      check_flag("done", 1'b1, done);
      check_flag("nack", nk, nack_seen);
      check_flag("all results", 1'b1, exp_rd.size() == 0 && exp_wr.size() == 0);
      for (n = 0; cmd_ready !== 1'b1 && n < 500; n++) @(negedge clock);
      check_flag("gap", 1'b1, n >= ((rd || nk) ? 0 : (susp ? 100 : 40)));
      check_flag("busy", 1'b0, busy);
   endtask

   // Controller frozen inside an ack, line held until watchdog is on
   task automatic lockup(input logic sel);
      int n, lim;
      lim = sel ? 4000 : 2000;
      nack_seen = 0;
      @(negedge clock);
      {cmd_read, cmd_reg, addr_sel, wdt_sel, wdt_en} = {1'b0, 8'h40, strap, sel, 1'b0};
      cmd_valid = 1;
      @(negedge clock);
      cmd_valid = 0;
      @(posedge i2c_link_if_i.dev_sda_oe);
      @(negedge clock);
      hold = 1;
      for (n = 0; wdt_trip !== 1'b1 && n < lim + 50; n++) @(negedge link_clk);
      check_flag("watchdog off", 1'b1, i2c_link_if_i.dev_sda_oe);
      wdt_en = 1;
      for (n = 0; wdt_trip !== 1'b1 && n < lim + 50; n++) @(negedge link_clk);
      check_flag("trip time", 1'b1, n >= lim - 1 && n <= lim + 1);
      check_flag("line freed", 1'b0, i2c_link_if_i.dev_sda_oe);
      @(negedge clock);
      hold = 0;
      for (n = 0; done !== 1'b1 && n < 9000; n++) @(negedge clock);
      check_flag("lockup nack", 1'b1, nack_seen);
      for (n = 0; cmd_ready !== 1'b1 && n < 500; n++) @(negedge clock);
   endtask

   // Main sequence
   initial begin
      for (int k = 0; k < 256; k++) begin
         regs[k] = 8'($random(seed));
         shadow[k] = regs[k];
      end
      repeat (20) @(negedge clock);
      rst_n = 1;
      repeat (3) @(negedge clock);
      check_byte("read pointer", 8'h00, rd_addr);
      for (int k = 0; k < 4; k++)
         run(1'b0, 8'($random(seed)), 8'($random(seed)), 8'h01, k[0], k[1], 1'b0);
      run(1'b0, 8'hfe, 8'($random(seed)), 8'h01, 1'b0, 1'b0, 1'b0);
      repeat (2) run(1'b1, 8'hfe, 8'h00, 8'h03, 1'b0, 1'b0, 1'b0);
      run(1'b0, 8'h21, 8'h5a, 8'h01, 1'b1, 1'b1, 1'b1);
      run(1'b1, 8'h21, 8'h00, 8'h01, 1'b1, 1'b1, 1'b0);
      run(1'b1, 8'h30, 8'h00, 8'h02, 1'b1, 1'b0, 1'b0);
      repeat (6)
         run(1'($random(seed)), 8'($random(seed)), 8'($random(seed)),
             8'(($random(seed) & 3) + 1), 1'b1, 1'($random(seed)), 1'($random(seed)));
      lockup(1'($random(seed)));
      summarize();
   end

   // Hang guard
   initial begin
      #4500000;
      failures++;
      summarize();
   end
endmodule // testbench
